// File: mswd_top.sv
// millisecond watchdog with axi4-lite register slave
//
// The implementer's own choice: register access over AXI4-Lite.
`include "mswd_defs.svh"
module mswd_top #(
  parameter int unsigned TICK_CYCLES = `MSWD_TICK_CYCLES  // cycles per 1 ms tick
) (
  input  wire logic        sys_clk_in,        // 10 MHz clock
  input  wire logic        rst_b_in,          // async reset, active low
  input  wire logic        running_power_state_in, // high while in running state
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic             tile_reset_out,    // high pulse resetting the processor tile
  output logic             irq_out            // level interrupt
);

  // register map, byte addresses from the constants header:
  //   timeout control  {live count, timeout}, the upper half is read-only
  //   disable key      zero enables, the key disables and clears the count
  //   restart          the restart key reloads the count from the timeout
  //   event status     {cause of tile reset, rejected write, expiry}, cleared on read
  //   event mask       one enable per event bit towards the interrupt
  // every output is a flop, so each answer lags its request by at least one
  // clock; a master must wait for valid rather than count cycles

  // power state pin synchroniser
  logic                    pwr_meta;          // first stage, read only by pwr_sync
  logic                    pwr_sync;          // safe running-state level

  // write channel capture
  logic                    aw_held;           // address taken, waiting for data
  logic [9:0]              aw_addr;           // captured byte address
  logic                    w_held;            // data taken, waiting for address
  logic [31:0]             w_data;            // captured write data
  logic [3:0]              w_strb;            // captured byte enables
  logic                    wr_go;             // both halves present, do the write

  // register state
  mswd_pkg::mswd_ctrl_t    ctrl;              // live count and timeout
  mswd_pkg::mswd_state_t   state;             // counter state
  logic [31:0]             disable_reg;       // last value written to disable register
  logic [1:0]              evt_status;        // sticky events
  logic [1:0]              evt_mask;          // interrupt mask
  logic                    wd_caused_reset;   // tile reset came from expiry

  // decoded write strobes
  logic                    wr_tmo;            // write to timeout register, any byte enables
  logic                    tmo_ok;            // complement check passed
  logic                    wr_dis;            // write to disable register
  logic                    wr_restart;        // restart with key
  logic                    tick;              // one-cycle millisecond tick
  logic [23:0]             div_cnt;           // tick divider
  logic [4:0]              trst_cnt;          // tile reset pulse counter
  logic                    expire;            // expiry event this cycle
  logic                    rd_status;         // status register read this cycle
  logic [31:0]             next_rdata;        // read mux

  // two-flop synchroniser on the power-state pin
  // the pin moves with the power controller's timing, not ours; only pwr_sync
  // feeds logic, so a metastable first stage never reaches the counter
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwr_meta <= 1'b0;
      pwr_sync <= 1'b0;
    end else begin
      pwr_meta <= running_power_state_in;
      pwr_sync <= pwr_meta;
    end
  end

  // write address channel: accept while no address held and no response pending
  // ready toggles while idle; that costs a cycle per write at worst but keeps
  // ready a plain flop with no path from the master's valid
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_held           <= 1'b0;
      aw_addr           <= 10'h000;
      s_axi_awready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_held && !s_axi_awready_out && !s_axi_bvalid_out;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in[9:0];
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
    end
  end

  // write data channel, taken independently of the address
  // mirrors the address channel so both halves normally land on one edge
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      w_held           <= 1'b0;
      w_data           <= 32'h00000000;
      w_strb           <= 4'h0;
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_wready_out <= !w_held && !s_axi_wready_out && !s_axi_bvalid_out;
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write decode; runs once both halves are held and no response is pending
  // a timeout write must carry all four byte lanes: anything less cannot hold
  // the value together with its complement, so it is refused
  always_comb begin
    wr_go      = aw_held && w_held && !s_axi_bvalid_out;
    wr_tmo     = wr_go && (aw_addr == `MSWD_ADDR_TIMEOUT_CTRL);
    tmo_ok     = (w_strb == 4'hF) && (w_data[31:16] == ~w_data[15:0]);
    wr_dis     = wr_go && (aw_addr == `MSWD_ADDR_DISABLE_KEY) && (w_strb == 4'hF);
    wr_restart = wr_go && (aw_addr == `MSWD_ADDR_RESTART) && (w_data == `MSWD_RESTART_KEY);
  end

  // write response: slverr for a failed complement check or an unmapped address
  // the response stands until bready, and no new write is taken meanwhile,
  // so a slow master can never lose an answer
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= mswd_pkg::MSWD_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      if (wr_tmo && !tmo_ok) begin
        s_axi_bresp_out <= mswd_pkg::MSWD_RESP_SLVERR;
      end else if (aw_addr == `MSWD_ADDR_TIMEOUT_CTRL || aw_addr == `MSWD_ADDR_DISABLE_KEY ||
                   aw_addr == `MSWD_ADDR_RESTART || aw_addr == `MSWD_ADDR_EVT_STATUS ||
                   aw_addr == `MSWD_ADDR_EVT_MASK) begin
        s_axi_bresp_out <= mswd_pkg::MSWD_RESP_OKAY;
      end else begin
        s_axi_bresp_out <= mswd_pkg::MSWD_RESP_SLVERR;
      end
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // millisecond tick divider, free running on the system clock
  // it never stops or restarts, so the first tick after an enable or restart
  // falls anywhere within one period: expiry comes after timeout-1 to timeout ms
  // limitation: software needing the full period must program one extra tick
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_cnt <= 24'h000000;
      tick    <= 1'b0;
    end else if (div_cnt == 24'(TICK_CYCLES - 1)) begin
      div_cnt <= 24'h000000;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 24'h000001;
      tick    <= 1'b0;
    end
  end

  // timeout field: a rejected write leaves it alone
  // only the lower half is stored; the upper half of a write is the complement
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl.timeout <= `MSWD_TMO_RESET;
    end else if (wr_tmo && tmo_ok) begin
      ctrl.timeout <= w_data[`MSWD_TMO_MSB:`MSWD_TMO_LSB];
    end
  end

  // disable register holds last written value; key is its reset value
  // values other than zero and the key are stored and read back but act on
  // nothing, so a stray write cannot half-enable the watchdog
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      disable_reg <= `MSWD_DISABLE_KEY;
    end else if (wr_dis) begin
      disable_reg <= w_data;
    end
  end

  // counter state machine; only ticks in the running power state
  // priority: the disable key beats everything, then enable, then a fresh
  // timeout, then a restart; only with none of them does the count move
  // leaving the running state freezes the count where it stands rather than
  // clearing it, so a short quiescent spell does not grant a fresh timeout
  assign expire = (state == mswd_pkg::MSWD_ST_RUN) && tick && pwr_sync &&
                  (ctrl.count <= 16'h0001);
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state      <= mswd_pkg::MSWD_ST_OFF;
      ctrl.count <= 16'h0000;
    end else if (wr_dis && w_data == `MSWD_DISABLE_KEY) begin
      state      <= mswd_pkg::MSWD_ST_OFF;
      ctrl.count <= 16'h0000;
    end else if (wr_dis && w_data == `MSWD_ENABLE_VALUE) begin
      state      <= mswd_pkg::MSWD_ST_RUN;
      ctrl.count <= ctrl.timeout;
    end else if (wr_tmo && tmo_ok) begin
      ctrl.count <= w_data[`MSWD_TMO_MSB:`MSWD_TMO_LSB];
    end else if (wr_restart) begin
      ctrl.count <= ctrl.timeout;
    end else begin
      case (state)
        mswd_pkg::MSWD_ST_OFF: begin
          ctrl.count <= ctrl.count;                      // disabled, hold
        end
        mswd_pkg::MSWD_ST_RUN: begin
          if (expire) begin
            state      <= mswd_pkg::MSWD_ST_EXPIRED;
            ctrl.count <= 16'h0000;
          end else if (tick && pwr_sync) begin
            ctrl.count <= ctrl.count - 16'h0001;
          end
        end
        mswd_pkg::MSWD_ST_EXPIRED: begin
          // tile is being reset; restart from the timeout after the pulse
          if (trst_cnt == 5'h01) begin
            state      <= mswd_pkg::MSWD_ST_RUN;
            ctrl.count <= ctrl.timeout;
          end
        end
        default: begin
          state <= mswd_pkg::MSWD_ST_OFF;
        end
      endcase
    end
  end

  // tile reset pulse of fixed length after expiry
  // the pulse is counted here, not in the tile, so it stays full length even
  // while the tile it resets is in disarray
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trst_cnt       <= 5'h00;
      tile_reset_out <= 1'b0;
    end else if (expire) begin
      trst_cnt       <= 5'(`MSWD_TILE_RST_CYCLES);
      tile_reset_out <= 1'b1;
    end else if (trst_cnt != 5'h00) begin
      trst_cnt       <= trst_cnt - 5'h01;
      tile_reset_out <= (trst_cnt != 5'h01);
    end
  end

  // boot-readable cause flag; survives tile reset, cleared by a status read
  // only the block reset clears it otherwise, so boot code sees it after the
  // tile reset it reports
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wd_caused_reset <= 1'b0;
    end else if (expire) begin
      wd_caused_reset <= 1'b1;
    end else if (rd_status) begin
      wd_caused_reset <= 1'b0;
    end
  end

  // sticky events; a set in the clearing read cycle wins
  // losing the set would hide an expiry that landed under the read
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      evt_status <= 2'b00;
    end else begin
      evt_status[`MSWD_EVT_EXPIRE] <= expire ||
        (evt_status[`MSWD_EVT_EXPIRE] && !rd_status);
      evt_status[`MSWD_EVT_REJECT] <= (wr_tmo && !tmo_ok) ||
        (evt_status[`MSWD_EVT_REJECT] && !rd_status);
    end
  end

  // mask register and interrupt output
  // the interrupt is registered from status and mask, so it trails a new
  // event or a clearing read by one clock
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      evt_mask <= 2'b00;
      irq_out  <= 1'b0;
    end else begin
      if (wr_go && aw_addr == `MSWD_ADDR_EVT_MASK && w_strb[0]) begin
        evt_mask <= w_data[1:0];
      end
      irq_out <= |(evt_status & evt_mask);
    end
  end

  // read mux
  // decoded straight from the address bus; it is sampled only at the address
  // handshake, when the master must hold the address stable
  assign rd_status = s_axi_arvalid_in && s_axi_arready_out &&
                     (s_axi_araddr_in[9:0] == `MSWD_ADDR_EVT_STATUS);
  always_comb begin
    case (s_axi_araddr_in[9:0])
      `MSWD_ADDR_TIMEOUT_CTRL: next_rdata = ctrl;
      `MSWD_ADDR_DISABLE_KEY:  next_rdata = disable_reg;
      `MSWD_ADDR_EVT_STATUS:   next_rdata = {29'h0, wd_caused_reset, evt_status};
      `MSWD_ADDR_EVT_MASK:     next_rdata = {30'h0, evt_mask};
      default:                 next_rdata = 32'h00000000;
    endcase
  end

  // read channel: one read at a time, answer the cycle after the address
  // data are captured at the handshake and stand until rready, so a slow
  // master reads the values of that edge even if the count moves on
  // a status read clears the events at that same edge
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= mswd_pkg::MSWD_RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out && !s_axi_arvalid_in ?
                           1'b1 : (!s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out));
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= next_rdata;
        case (s_axi_araddr_in[9:0])
          `MSWD_ADDR_TIMEOUT_CTRL, `MSWD_ADDR_DISABLE_KEY, `MSWD_ADDR_RESTART,
          `MSWD_ADDR_EVT_STATUS, `MSWD_ADDR_EVT_MASK:
            s_axi_rresp_out <= mswd_pkg::MSWD_RESP_OKAY;
          default:
            s_axi_rresp_out <= mswd_pkg::MSWD_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

endmodule : mswd_top

// File: mswd_defs.svh
// constants of the millisecond watchdog: offsets, fields, reset values, timing
// Behaviour
// - count the timeout in one-millisecond ticks
// - counter advances only in running power state
// - timeout write needs complement check, else slverr
// - expiry while enabled resets the processor tile
// - each restart reloads count from programmed timeout
// - upper half reads live count, zero after reset
// - lower half holds timeout, resets to 1000
// - writing zero to disable register enables watchdog
// - disable key resets counter and disables watchdog
// - boot program can read watchdog-caused-reset flag
`ifndef MSWD_DEFS_SVH
`define MSWD_DEFS_SVH
// register indices as printed; byte address is four times the index
`define MSWD_IDX_TIMEOUT_CTRL   8'hD6
`define MSWD_IDX_DISABLE_KEY    8'hD7
`define MSWD_IDX_RESTART        8'hD8
`define MSWD_IDX_EVT_STATUS     8'hD9
`define MSWD_IDX_EVT_MASK       8'hDA
`define MSWD_ADDR_TIMEOUT_CTRL  10'h358
`define MSWD_ADDR_DISABLE_KEY   10'h35C
`define MSWD_ADDR_RESTART       10'h360
`define MSWD_ADDR_EVT_STATUS    10'h364
`define MSWD_ADDR_EVT_MASK      10'h368
// field positions
`define MSWD_CNT_MSB            31
`define MSWD_CNT_LSB            16
`define MSWD_TMO_MSB            15
`define MSWD_TMO_LSB            0
// reset values and keys
`define MSWD_TMO_RESET          16'h03E8
`define MSWD_DISABLE_KEY        32'h0D15AB1E
`define MSWD_ENABLE_VALUE       32'h00000000
`define MSWD_RESTART_KEY        32'h0000600D
// event bits: bit0 expiry, bit1 rejected timeout write
`define MSWD_EVT_EXPIRE         0
`define MSWD_EVT_REJECT         1
// timing: clock 10 MHz, tick period 1 ms
`define MSWD_CLK_HZ             10000000
`define MSWD_TICK_NS            1000000
`define MSWD_CLK_NS             100
`define MSWD_TICK_CYCLES        (`MSWD_TICK_NS / `MSWD_CLK_NS)
// tile reset pulse length
`define MSWD_TILE_RST_CYCLES    16
`endif

// File: mswd_pkg.sv
// types of the millisecond watchdog
package mswd_pkg;
  // axi write response codes
  typedef enum logic [1:0] {
    MSWD_RESP_OKAY   = 2'b00,
    MSWD_RESP_SLVERR = 2'b10
  } mswd_resp_t;
  // counter state
  typedef enum logic [1:0] {
    MSWD_ST_OFF     = 2'b00,
    MSWD_ST_RUN     = 2'b01,
    MSWD_ST_EXPIRED = 2'b10
  } mswd_state_t;
  // watchdog core status seen by software
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] timeout;
  } mswd_ctrl_t;
endpackage : mswd_pkg

// File: mswd_assertions.sv
// port checker of the millisecond watchdog
module mswd_assertions #(
  parameter int unsigned TICK_CYCLES = 10  // cycles per tick, unused here
) (
  input wire logic        sys_clk_in,
  input wire logic        rst_b_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        tile_reset_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [4:0] hi_run;  // cycles the tile reset has stood high so far
  // pulse length counter; a stuck pulse wraps, which the bound check catches first
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) hi_run <= 5'h00;
    else if (tile_reset_out) hi_run <= hi_run + 5'h01;
    else hi_run <= 5'h00;
  end
  // both write halves taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid_out)
    else $error("write response late");
  chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_out)
    else $error("read data late");
  chk_bresp_code: assert property (s_axi_bvalid_out |-> s_axi_bresp_out inside {2'b00, 2'b10})
    else $error("bad write response code");
  chk_bvalid_held: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  chk_rdata_held: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  chk_write_block: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken during response");
  chk_read_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken during data");
  chk_pulse_bound: assert property (tile_reset_out |-> hi_run < 5'd16)
    else $error("tile reset too long");
  chk_pulse_len: assert property ($fell(tile_reset_out) |-> hi_run == 5'd16)
    else $error("tile reset pulse not 16 cycles");
endmodule : mswd_assertions

bind mswd_top mswd_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .tile_reset_out(tile_reset_out));

// File: test_millisecond_watchdog.sv
// self-checking bench of the millisecond watchdog
`include "mswd_defs.svh"
module test_millisecond_watchdog;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TICK = 10;  // short tick keeps the run brief
  localparam logic [31:0] A_CTL = 32'(`MSWD_ADDR_TIMEOUT_CTRL);
  localparam logic [31:0] A_KEY = 32'(`MSWD_ADDR_DISABLE_KEY);
  localparam logic [31:0] A_RST = 32'(`MSWD_ADDR_RESTART);
  localparam logic [31:0] A_STA = 32'(`MSWD_ADDR_EVT_STATUS);
  localparam logic [31:0] A_MSK = 32'(`MSWD_ADDR_EVT_MASK);
  logic        sys_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        pwr = 1'b1;            // running power state
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, tile_rst, irq;
  logic [1:0]  bresp, rresp;
  int          n_fail = 0;
  int          compares = 0;
  mswd_top #(.TICK_CYCLES(TICK)) dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .running_power_state_in(pwr), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .tile_reset_out(tile_rst), .irq_out(irq));
  always #50 sys_clk_in = ~sys_clk_in;  // 10 MHz
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  // a wait that runs out ends the run at once
  task automatic hang(input string m);
    chk(1'b0, m);
    end_of_test();
  endtask : hang
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask : cyc
  // both write halves offered together, each dropped as it is taken; bready may lag
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r, input int lag = 0);
    @(posedge sys_clk_in);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= (lag == 0);
    for (int n = 0; n < 64; n++) begin
      @(posedge sys_clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
      if (n + 1 >= lag) bready <= 1'b1;
    end
    hang("write not answered");
  endtask : wr
  // a lagging rready leaves the read data standing for some cycles
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r,
                    input int lag = 0);
    @(posedge sys_clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= (lag == 0);
    for (int n = 0; n < 64; n++) begin
      @(posedge sys_clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
      if (n + 1 >= lag) rready <= 1'b1;
    end
    hang("read not answered");
  endtask : rd
  // reset values and an unmapped place
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd(A_CTL, d, r);
    chk(d === {16'h0000, `MSWD_TMO_RESET}, "control reset");
    rd(A_KEY, d, r);
    chk(d === `MSWD_DISABLE_KEY, "disable reset");
    rd(32'h0000_0300, d, r);
    chk(r === mswd_pkg::MSWD_RESP_SLVERR, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  // refused timeout writes, the event they raise, mask and clear of irq
  task automatic t_reject;
    logic [31:0] d;
    logic [1:0]  r;
    wr(A_MSK, 32'h0, 4'hF, r);
    wr(A_CTL, 32'h1234_0005, 4'hF, r);
    chk(r === mswd_pkg::MSWD_RESP_SLVERR, "bad complement taken");
    wr(A_CTL, 32'hFFFA_0005, 4'h3, r);
    chk(r === mswd_pkg::MSWD_RESP_SLVERR, "partial write taken");
    rd(A_CTL, d, r);
    chk(d === {16'h0000, `MSWD_TMO_RESET}, "refused write changed timeout or count");
    cyc(2);
    chk(irq === 1'b0, "masked event raised irq");
    wr(A_MSK, 32'h3, 4'hF, r);
    rd(A_MSK, d, r, 3);
    chk(d === 32'h0000_0003, "mask readback");
    wr(32'h0000_0300, 32'h0, 4'hF, r, 3);
    chk(r === mswd_pkg::MSWD_RESP_SLVERR, "unmapped write taken");
    cyc(2);
    chk(irq === 1'b1, "unmasked event gave no irq");
    rd(A_STA, d, r);
    chk(d[`MSWD_EVT_REJECT] === 1'b1, "refusal event missing");
    cyc(2);
    chk(irq === 1'b0, "status read left irq high");
    wr(A_CTL, 32'hFFFA_0005, 4'hF, r);
    chk(r === mswd_pkg::MSWD_RESP_OKAY, "good timeout refused");
    rd(A_CTL, d, r);
    chk(d === 32'h0005_0005, "timeout not stored or count not loaded");
    $display("test reject done");
  endtask : t_reject
  // enable, count down, restart, hold while not running, expiry, disable
  task automatic t_count;
    logic [31:0] d;
    logic [31:0] c;
    logic [1:0]  r;
    int          n;
    bit          seen;
    wr(A_KEY, `MSWD_ENABLE_VALUE, 4'hF, r);
    rd(A_CTL, d, r);
    chk(d[31:16] inside {16'h0004, 16'h0005}, "enable did not load count");
    cyc(2 * TICK);
    rd(A_CTL, d, r);
    chk(d[31:16] inside {16'h0002, 16'h0003}, "count not per tick");
    wr(A_RST, `MSWD_RESTART_KEY, 4'hF, r);
    pwr <= 1'b0;
    rd(A_CTL, d, r);
    chk(d[31:16] inside {16'h0004, 16'h0005}, "restart did not reload");
    cyc(3);
    rd(A_CTL, c, r);
    cyc(6 * TICK);
    rd(A_CTL, d, r);
    chk(d[31:16] === c[31:16], "count moved while quiescent");
    pwr <= 1'b1;
    cyc(3);
    wr(A_RST, `MSWD_RESTART_KEY, 4'hF, r);
    for (n = 0; n < 8 * TICK && !tile_rst; n++) @(posedge sys_clk_in);
    if (n == 8 * TICK) hang("no expiry");
    else chk(n >= 4 * TICK - 3 && n <= 5 * TICK + 3, "expiry time");
    cyc(2);
    chk(irq === 1'b1, "expiry gave no irq");
    rd(A_STA, d, r);
    chk(d[2:0] === 3'b101, "expiry events");
    wr(A_KEY, `MSWD_DISABLE_KEY, 4'hF, r);
    rd(A_CTL, d, r);
    chk(d[31:16] === 16'h0000, "disable left count");
    wr(A_RST, 32'h0000_0BAD, 4'hF, r);
    rd(A_CTL, d, r);
    chk(d[31:16] === 16'h0000, "restart without key reloaded");
    seen = 1'b0;
    repeat (8 * TICK) @(posedge sys_clk_in) seen |= (tile_rst !== 1'b0);
    chk(!seen, "expiry while disabled");
    $display("test count done");
  endtask : t_count
  initial begin
    cyc(16);
    rst_b_in <= 1'b1;
    t_reset();
    t_reject();
    t_count();
    end_of_test();
  end
endmodule : test_millisecond_watchdog
